/* File: inc/gtlim_pkg.sv */
// Package with register map, field positions and reset values of the interrupt mask block
package gtlim_pkg;
    // ========================================
    // Register indices (printed offsets) and byte addresses
    localparam logic [7:0] GTLIM_IDX_BUS_EVENT = 8'h02;
    localparam logic [7:0] GTLIM_IDX_ADDR_STATE = 8'h04;
    localparam logic [7:0] GTLIM_IDX_GLOBAL_LINK = 8'h1d;
    localparam logic [7:0] GTLIM_IDX_AUX_CMD = 8'h05;
    localparam logic [7:0] GTLIM_IDX_TERM_CHAR = 8'h08;
    localparam logic [7:0] GTLIM_IDX_STATUS0 = 8'h20;
    localparam logic [7:0] GTLIM_IDX_EVT_STAT = 8'h21;
    localparam logic [7:0] GTLIM_IDX_EVT_CLR = 8'h22;
    localparam logic [7:0] GTLIM_IDX_EVT_EN = 8'h23;
    localparam logic [1:0] GTLIM_IDX_SHIFT = 2'h2;
    // ========================================
    // Reset values
    localparam logic [7:0] GTLIM_RST_BUS_EVENT = 8'h00;
    localparam logic [7:0] GTLIM_RST_ADDR_STATE = 8'h00;
    localparam logic [7:0] GTLIM_RST_GLOBAL_LINK = 8'h80;
    localparam logic [7:0] GTLIM_RST_TERM_CHAR = 8'h00;
    // ========================================
    // Global and link mask fields
    localparam int GTLIM_B_GATE = 7;
    localparam int GTLIM_B_POLL = 6;
    localparam int GTLIM_B_LF = 5;
    localparam int GTLIM_B_RESTART = 4;
    localparam int GTLIM_B_IFC = 3;
    localparam int GTLIM_B_ATN = 2;
    localparam int GTLIM_B_EXPIRY = 1;
    localparam int GTLIM_B_LOCKSTEP = 0;
    // Address state mask uses bits 2..0 only
    localparam logic [7:0] GTLIM_ADDR_STATE_USED = 8'h07;
    // ========================================
    // Auxiliary command codes and character constants
    localparam logic [7:0] GTLIM_CMD_SW_RESET = 8'h02;
    localparam logic [6:0] GTLIM_NEWLINE = 7'h0a;
    localparam logic [1:0] GTLIM_RESP_OKAY = 2'h0;
    localparam logic [1:0] GTLIM_RESP_SLVERR = 2'h2;
    // Event bits of the sticky event register
    localparam int GTLIM_EV_POLL = 0;
    localparam int GTLIM_EV_TERM = 1;
    localparam int GTLIM_EV_LF = 2;
    localparam int GTLIM_NUM_EV = 3;
endpackage

/* File: hdl/gtlim_core.sv */
// Interrupt mask and link control block of a bus talker/listener, AXI4-Lite slave
// How it works
// - Global gate bit 7 blocks every status-register interrupt while clear.
// - Software keeps the gate set; software-reset command sets the gate.
// - Poll interrupt enable bit 6 selects serial poll mode two.
// - With bit 6 set, entering serial poll active raises an interrupt.
// - Linefeed enable bit 5 makes accepted 7-bit 0x0a a terminator.
// - Accepted newline with bit 5 acts as if EOI came with it.
// - Newline and terminator register character both recognised when bit 5 set.
// - Restart bit 4 restarts the timer per data byte and sent command.
// - Interface-clear enable bit 3 passes the interface-clear condition.
// - Attention enable bit 2 passes the attention condition.
// - Expiry enable bit 1 passes the timer timeout condition.
// - Lockstep enable bit 0 passes the bus-synchronized condition.
// - Bus event mask bits 7..0 enable the eight bus event conditions.
// - Address state mask bits 2..0 enable three conditions; bits 7..3 zero.
// - Newline-received flag follows the last accepted byte, ignoring bit 5.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
module gtlim_core
    import gtlim_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Status conditions from the status registers
    input wire logic [7:0] global_link_status,
    input wire logic [7:0] bus_event_status,
    input wire logic [7:0] address_state_status,
    // Acceptor and source events
    input wire logic serial_poll_active,
    input wire logic byte_accepted,
    input wire logic [7:0] accepted_byte,
    input wire logic data_byte_sent,
    input wire logic command_byte_sent,
    // Control outputs
    output logic serial_poll_mode_two,
    output logic end_as_eoi,
    output logic terminator_match,
    output logic newline_received_flag,
    output logic timer_restart,
    output logic host_irq,
    output logic event_irq
);
    // ========================================
    // Write channel state
    logic aw_got_q;
    logic w_got_q;
    logic [7:0] aw_idx_q;
    logic [7:0] wdata_q;
    logic wlane_q;
    logic [7:0] bus_event_irq_mask_q;
    logic [7:0] address_state_irq_mask_q;
    logic [7:0] global_and_link_irq_mask_q;
    logic [7:0] terminator_char_register_q;
    logic [GTLIM_NUM_EV-1:0] evt_stat_q;
    logic [GTLIM_NUM_EV-1:0] evt_en_q;
    logic [GTLIM_NUM_EV-1:0] evt_set;
    logic poll_q;
    logic do_write;
    logic wr_ok;
    logic is_nl;
    logic is_term;
    logic [7:0] gl_masked;
    logic [7:0] be_masked;
    logic [7:0] as_masked;

    assign do_write = aw_got_q && w_got_q && !s_axi_bvalid;
    assign wr_ok = do_write && wlane_q;

    // Capture write address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_idx_q <= 8'h00;
            wdata_q <= 8'h00;
            wlane_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_got_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_got_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr >> GTLIM_IDX_SHIFT;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata[7:0];
                wlane_q <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
            end
        end
    end

    // Write response, error on unmapped index
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= GTLIM_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            if (aw_idx_q == GTLIM_IDX_BUS_EVENT || aw_idx_q == GTLIM_IDX_ADDR_STATE ||
                aw_idx_q == GTLIM_IDX_GLOBAL_LINK || aw_idx_q == GTLIM_IDX_AUX_CMD ||
                aw_idx_q == GTLIM_IDX_TERM_CHAR || aw_idx_q == GTLIM_IDX_EVT_CLR ||
                aw_idx_q == GTLIM_IDX_EVT_EN) begin
                s_axi_bresp <= GTLIM_RESP_OKAY;
            end else begin
                s_axi_bresp <= GTLIM_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Mask registers; software reset command sets the gate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_event_irq_mask_q <= GTLIM_RST_BUS_EVENT;
            address_state_irq_mask_q <= GTLIM_RST_ADDR_STATE;
            global_and_link_irq_mask_q <= GTLIM_RST_GLOBAL_LINK;
            terminator_char_register_q <= GTLIM_RST_TERM_CHAR;
            evt_en_q <= '0;
        end else if (wr_ok) begin
            if (aw_idx_q == GTLIM_IDX_BUS_EVENT) begin
                bus_event_irq_mask_q <= wdata_q;
            end else if (aw_idx_q == GTLIM_IDX_ADDR_STATE) begin
                address_state_irq_mask_q <= wdata_q & GTLIM_ADDR_STATE_USED;
            end else if (aw_idx_q == GTLIM_IDX_GLOBAL_LINK) begin
                global_and_link_irq_mask_q <= wdata_q;
            end else if (aw_idx_q == GTLIM_IDX_AUX_CMD) begin
                if (wdata_q == GTLIM_CMD_SW_RESET) begin
                    global_and_link_irq_mask_q[GTLIM_B_GATE] <= 1'b1;
                end
            end else if (aw_idx_q == GTLIM_IDX_TERM_CHAR) begin
                terminator_char_register_q <= wdata_q;
            end else if (aw_idx_q == GTLIM_IDX_EVT_EN) begin
                evt_en_q <= wdata_q[GTLIM_NUM_EV-1:0];
            end
        end
    end

    // Read channel; mask registers are write only and answer SLVERR with zero data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= GTLIM_RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= GTLIM_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            if ((s_axi_araddr >> GTLIM_IDX_SHIFT) == GTLIM_IDX_STATUS0) begin
                s_axi_rdata[7:0] <= global_link_status;
            end else if ((s_axi_araddr >> GTLIM_IDX_SHIFT) == GTLIM_IDX_EVT_STAT) begin
                s_axi_rdata[GTLIM_NUM_EV-1:0] <= evt_stat_q;
            end else if ((s_axi_araddr >> GTLIM_IDX_SHIFT) == GTLIM_IDX_EVT_EN) begin
                s_axi_rdata[GTLIM_NUM_EV-1:0] <= evt_en_q;
            end else if ((s_axi_araddr >> GTLIM_IDX_SHIFT) == GTLIM_IDX_TERM_CHAR) begin
                s_axi_rdata[7:0] <= terminator_char_register_q;
            end else begin
                s_axi_rresp <= GTLIM_RESP_SLVERR;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ========================================
    // Acceptor terminator detection
    assign is_nl = (accepted_byte[6:0] == GTLIM_NEWLINE);
    assign is_term = (accepted_byte == terminator_char_register_q) ||
        (global_and_link_irq_mask_q[GTLIM_B_LF] && is_nl);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            newline_received_flag <= 1'b0;
            end_as_eoi <= 1'b0;
            terminator_match <= 1'b0;
        end else begin
            end_as_eoi <= byte_accepted && global_and_link_irq_mask_q[GTLIM_B_LF] && is_nl;
            terminator_match <= byte_accepted && is_term;
            if (byte_accepted) begin
                newline_received_flag <= (accepted_byte == {1'b0, GTLIM_NEWLINE});
            end
        end
    end

    // Serial poll mode and timer restart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_poll_mode_two <= 1'b0;
            timer_restart <= 1'b0;
            poll_q <= 1'b0;
        end else begin
            serial_poll_mode_two <= global_and_link_irq_mask_q[GTLIM_B_POLL];
            timer_restart <= global_and_link_irq_mask_q[GTLIM_B_RESTART] &&
                ((byte_accepted || data_byte_sent) || command_byte_sent);
            poll_q <= serial_poll_active;
        end
    end

    // ========================================
    // Host interrupt combine
    always_comb begin
        gl_masked = global_link_status & global_and_link_irq_mask_q;
        gl_masked[GTLIM_B_LF] = 1'b0;
        gl_masked[GTLIM_B_RESTART] = 1'b0;
        // Poll condition is the active state or status bit 6, under bit 6
        gl_masked[GTLIM_B_POLL] = global_and_link_irq_mask_q[GTLIM_B_POLL] &&
            (serial_poll_active || global_link_status[GTLIM_B_POLL]);
        gl_masked[GTLIM_B_GATE] = 1'b0;
        be_masked = bus_event_status & bus_event_irq_mask_q;
        as_masked = address_state_status & address_state_irq_mask_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_irq <= 1'b0;
        end else begin
            host_irq <= global_and_link_irq_mask_q[GTLIM_B_GATE] &&
                (|gl_masked || |be_masked || |as_masked);
        end
    end

    // Sticky events: set wins over clear
    assign evt_set[GTLIM_EV_POLL] = serial_poll_active && !poll_q;
    assign evt_set[GTLIM_EV_TERM] = byte_accepted && is_term;
    assign evt_set[GTLIM_EV_LF] = byte_accepted && is_nl;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_stat_q <= '0;
            event_irq <= 1'b0;
        end else begin
            if (wr_ok && aw_idx_q == GTLIM_IDX_EVT_CLR) begin
                evt_stat_q <= (evt_stat_q & ~wdata_q[GTLIM_NUM_EV-1:0]) | evt_set;
            end else begin
                evt_stat_q <= evt_stat_q | evt_set;
            end
            event_irq <= |(evt_stat_q & evt_en_q);
        end
    end

    // ========================================
    // Checks
    sequence s_gate_write;
        wr_ok && aw_idx_q == GTLIM_IDX_GLOBAL_LINK && !wdata_q[GTLIM_B_GATE];
    endsequence

    a_gate_blocks_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        !global_and_link_irq_mask_q[GTLIM_B_GATE] |=> !host_irq)
        else $error("host interrupt while gate clear");
    a_swrst_sets_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_ok && aw_idx_q == GTLIM_IDX_AUX_CMD && wdata_q == GTLIM_CMD_SW_RESET
        |=> global_and_link_irq_mask_q[GTLIM_B_GATE])
        else $error("software reset did not set gate");
    a_gate_clear_write: assert property (@(posedge aclk) disable iff (!aresetn)
        s_gate_write |=> ##1 !host_irq)
        else $error("interrupt after gate cleared");
    a_poll_mode_two: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 serial_poll_mode_two == $past(global_and_link_irq_mask_q[GTLIM_B_POLL]))
        else $error("poll mode does not follow enable");
    a_poll_raises_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        serial_poll_active && global_and_link_irq_mask_q[GTLIM_B_POLL] &&
        global_and_link_irq_mask_q[GTLIM_B_GATE] |=> host_irq)
        else $error("serial poll gave no interrupt");
    a_newline_eoi: assert property (@(posedge aclk) disable iff (!aresetn)
        byte_accepted && accepted_byte[6:0] == GTLIM_NEWLINE &&
        global_and_link_irq_mask_q[GTLIM_B_LF] |=> end_as_eoi && terminator_match)
        else $error("newline not treated as end");
    a_restart_timer: assert property (@(posedge aclk) disable iff (!aresetn)
        command_byte_sent && global_and_link_irq_mask_q[GTLIM_B_RESTART] |=> timer_restart)
        else $error("timer not restarted");
    a_newline_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        byte_accepted |=> newline_received_flag == ($past(accepted_byte) == 8'h0a))
        else $error("newline flag wrong");
    a_addr_unused_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        address_state_irq_mask_q[7:3] == 5'h00)
        else $error("unused address mask bits set");
endmodule

/* File: testbench/gtlim_bus_peer.sv */
// Bus-side peer model: drives acceptor, source and serial poll events
`timescale 1ns/1ns
module gtlim_bus_peer (
    // Clock
    input wire logic aclk,
    // Events toward the block
    output logic serial_poll_active,
    output logic byte_accepted,
    output logic [7:0] accepted_byte,
    output logic data_byte_sent,
    output logic command_byte_sent
);
    // ========================================
    // Idle values at time zero
    initial begin
        serial_poll_active = 1'b0;
        byte_accepted = 1'b0;
        accepted_byte = 8'h55;
        data_byte_sent = 1'b0;
        command_byte_sent = 1'b0;
    end
    // One accepted byte; the data lines show the inverse once released
    task automatic accept(input logic [7:0] b);
        @(posedge aclk);
        byte_accepted <= 1'b1;
        accepted_byte <= b;
        @(posedge aclk);
        byte_accepted <= 1'b0;
        accepted_byte <= ~b;
    endtask
    // One sent byte: data when cmd is low, command otherwise
    task automatic send(input logic cmd);
        @(posedge aclk);
        data_byte_sent <= !cmd;
        command_byte_sent <= cmd;
        @(posedge aclk);
        data_byte_sent <= 1'b0;
        command_byte_sent <= 1'b0;
    endtask
    // Controller enters or leaves a serial poll of this device
    task automatic poll(input logic on);
        @(posedge aclk);
        serial_poll_active <= on;
    endtask
endmodule

/* File: testbench/gpib_talker_listener_irq_masks_test.sv */
// Self-checking testbench of the interrupt mask block
`timescale 1ns/1ns
module gpib_talker_listener_irq_masks_test;
    import gtlim_pkg::*;
    // ========================================
    // Signals
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] gls = 8'h00, bes = 8'h00, ass = 8'h00, acc_b;
    logic spa, acc, dsent, csent, mode2, eoi, tmatch, nlf, trst, hirq, eirq;
    logic [31:0] rd;
    int failures = 0, n_checks = 0;
    // ========================================
    // Clock and reset
    initial begin
        forever #20 aclk = ~aclk;
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
    end
    gtlim_bus_peer i_peer (.aclk(aclk), .serial_poll_active(spa), .byte_accepted(acc),
        .accepted_byte(acc_b), .data_byte_sent(dsent), .command_byte_sent(csent));
    gtlim_core i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .global_link_status(gls), .bus_event_status(bes),
        .address_state_status(ass), .serial_poll_active(spa), .byte_accepted(acc),
        .accepted_byte(acc_b), .data_byte_sent(dsent), .command_byte_sent(csent),
        .serial_poll_mode_two(mode2), .end_as_eoi(eoi), .terminator_match(tmatch),
        .newline_received_flag(nlf), .timer_restart(trst), .host_irq(hirq),
        .event_irq(eirq));
    // ========================================
    // Verdict and compare
    task automatic finish_test();
        if (failures == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        finish_test();
    end
    // ========================================
    // Bus cycles; the byte address is four times the index
    task automatic axw(input logic [7:0] idx, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= idx << GTLIM_IDX_SHIFT;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] idx);
        araddr <= idx << GTLIM_IDX_SHIFT;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic settle();
        repeat (3) @(posedge aclk);
        #1;
    endtask
    // One mask and status setting, then the host interrupt level
    task automatic irq_case(input logic [7:0] gm, bm, am, gs, bs, as_, input logic e);
        axw(GTLIM_IDX_GLOBAL_LINK, {24'h0, gm});
        axw(GTLIM_IDX_BUS_EVENT, {24'h0, bm});
        axw(GTLIM_IDX_ADDR_STATE, {24'h0, am});
        gls <= gs;
        bes <= bs;
        ass <= as_;
        settle();
        chk(hirq, e);
    endtask
    // ========================================
    // Scenarios
    task automatic t_reset_gate();
        gls <= 8'h0f;
        bes <= 8'hff;
        ass <= 8'h07;
        settle();
        chk(hirq, 1'b0);
        chk(mode2, 1'b0);
        irq_case(8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 1'b0);
        axw(GTLIM_IDX_AUX_CMD, {24'h0, GTLIM_CMD_SW_RESET});
        settle();
        chk(hirq, 1'b1);
    endtask
    task automatic t_enables();
        for (int b = 0; b < 4; b++) begin
            irq_case(8'h80 | (8'h01 << b), 0, 0, 8'h01 << b, 0, 0, 1'b1);
            irq_case(8'h80 | (8'h01 << b), 0, 0, 8'hbf & ~(8'h01 << b), 0, 0, 1'b0);
            irq_case(8'h01 << b, 0, 0, 8'h01 << b, 0, 0, 1'b0);
        end
        for (int b = 0; b < 8; b++) begin
            irq_case(8'h80, 8'h01 << b, 0, 0, 8'h01 << b, 0, 1'b1);
            irq_case(8'h80, 8'h01 << b, 0, 0, ~(8'h01 << b), 0, 1'b0);
        end
        for (int b = 0; b < 3; b++) begin
            irq_case(8'h80, 0, 8'h01 << b, 0, 0, 8'h01 << b, 1'b1);
        end
        irq_case(8'h80, 0, 8'hf8, 0, 0, 8'hff, 1'b0);
        gls <= 8'h00;
        bes <= 8'h00;
        ass <= 8'h00;
    endtask
    task automatic t_poll();
        irq_case(8'hc0, 0, 0, 0, 0, 0, 1'b0);
        chk(mode2, 1'b1);
        i_peer.poll(1'b1);
        settle();
        chk(hirq, 1'b1);
        i_peer.poll(1'b0);
        irq_case(8'h80, 0, 0, 0, 0, 0, 1'b0);
        chk(mode2, 1'b0);
    endtask
    task automatic t_newline();
        axw(GTLIM_IDX_TERM_CHAR, 32'h41);
        axw(GTLIM_IDX_GLOBAL_LINK, 32'ha0);
        axw(GTLIM_IDX_EVT_CLR, 32'h07);
        axw(GTLIM_IDX_EVT_EN, 32'h04);
        i_peer.accept(8'h0a);
        #1;
        chk({eoi, tmatch, nlf}, 3'b111);
        @(posedge aclk);
        #1;
        chk(eoi, 1'b0);
        chk(eirq, 1'b1);
        i_peer.accept(8'h41);
        #1;
        chk({tmatch, nlf}, 2'b10);
        i_peer.accept(8'h8a);
        #1;
        chk({eoi, nlf}, 2'b10);
        axr(GTLIM_IDX_EVT_STAT);
        chk(rd & 32'h4, 32'h4);
        axw(GTLIM_IDX_EVT_EN, 32'h00);
        settle();
        chk(eirq, 1'b0);
        axw(GTLIM_IDX_EVT_EN, 32'h04);
        settle();
        chk(eirq, 1'b1);
        axw(GTLIM_IDX_EVT_CLR, 32'h04);
        settle();
        chk(eirq, 1'b0);
        axw(GTLIM_IDX_GLOBAL_LINK, 32'h80);
        i_peer.accept(8'h0a);
        #1;
        chk({eoi, tmatch, nlf}, 3'b001);
    endtask
    task automatic t_restart();
        axw(GTLIM_IDX_GLOBAL_LINK, 32'h90);
        for (int k = 0; k < 2; k++) begin
            i_peer.send(k[0]);
            #1;
            chk(trst, 1'b1);
        end
        i_peer.accept(8'h33);
        #1;
        chk(trst, 1'b1);
        axw(GTLIM_IDX_GLOBAL_LINK, 32'h80);
        i_peer.send(1'b0);
        #1;
        chk(trst, 1'b0);
    endtask
    task automatic t_refused();
        axr(8'h3f);
        chk(resp, GTLIM_RESP_SLVERR);
        axr(GTLIM_IDX_GLOBAL_LINK);
        chk(resp, GTLIM_RESP_SLVERR);
        axw(8'h3e, 32'hff);
        chk(resp, GTLIM_RESP_SLVERR);
        axw(GTLIM_IDX_BUS_EVENT, 32'h00);
        chk(resp, GTLIM_RESP_OKAY);
        // Write without the low byte lane is answered but leaves the mask alone
        wstrb <= 4'h0;
        axw(GTLIM_IDX_BUS_EVENT, 32'hff);
        chk(resp, GTLIM_RESP_OKAY);
        wstrb <= 4'hf;
        bes <= 8'h01;
        settle();
        chk(hirq, 1'b0);
        bes <= 8'h00;
    endtask
    // ========================================
    // Main sequence
    initial begin
        wait (aresetn === 1'b1);
        @(posedge aclk);
        t_reset_gate();
        t_enables();
        t_poll();
        t_newline();
        t_restart();
        t_refused();
        finish_test();
    end
endmodule
